//--- shared/gpcp_defs.svh
/*
 * Offsets, field positions, reset values and timing constants for the
 * pin 7 configuration and pull-up enable block.
 * Assumes a 10 MHz ref_clk and a byte-wide register port.
 */
`ifndef GPCP_DEFS_SVH
`define GPCP_DEFS_SVH

// register offsets
`define GPCP_OFS_CFG7 8'h77
`define GPCP_OFS_PUE 8'h78
`define GPCP_OFS_IRQ_STAT 8'h7A
`define GPCP_OFS_IRQ_MASK 8'h7B
`define GPCP_OFS_PDE 8'h79

// pin 7 configuration fields
`define GPCP_DBNC_HI 7
`define GPCP_DBNC_LO 6
`define GPCP_EDGE_HI 5
`define GPCP_EDGE_LO 4
`define GPCP_BIT_DO 3
`define GPCP_BIT_DI 2
`define GPCP_BIT_DIR 1
`define GPCP_BIT_DRV 0
`define GPCP_PIN_NUM 7

// reset values
`define GPCP_RST_CFG7 8'h00
`define GPCP_RST_PUE 8'h00
`define GPCP_RST_IRQ 2'h0

// status bits: falling event, rising event
`define GPCP_IRQ_FALL 0
`define GPCP_IRQ_RISE 1

// debounce times and clock rate
`define GPCP_CLK_HZ 10000000
`define GPCP_DB8_MS 8
`define GPCP_DB16_MS 16
`define GPCP_DB32_MS 32
`define GPCP_MS_CYC(ms) ((ms) * (`GPCP_CLK_HZ / 1000))

`endif

//--- shared/gpcp_pkg.sv
/*
 * Types for the pin 7 configuration and pull-up enable block.
 * Assumes gpcp_defs.svh is on the include path.
 */
package gpcp_pkg;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } gpcp_req_t;

   // pin drive toward the pad
   typedef struct packed {
      logic out;
      logic oe;
   } gpcp_pad_t;

   // debounce selection
   typedef enum logic [1:0] {
      GPCP_DB_NONE = 2'b00,
      GPCP_DB_8MS = 2'b01,
      GPCP_DB_16MS = 2'b10,
      GPCP_DB_32MS = 2'b11
   } gpcp_db_t;

   // debounce filter state
   typedef enum logic [0:0] {
      GPCP_ST_STABLE = 1'b0,
      GPCP_ST_CHANGE = 1'b1
   } gpcp_st_t;

endpackage : gpcp_pkg

//--- src/gpcp_pin7.sv
/*
 * Pin 7 configuration register, shared pull-up enable register, input
 * debounce, edge interrupt and output drive for a general purpose pin.
 * Assumes a byte register port with read data one cycle after the strobe,
 * and a pad input synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "gpcp_defs.svh"

module gpcp_pin7 #(
   parameter int DB8_CYC = `GPCP_MS_CYC(`GPCP_DB8_MS),
   parameter int DB16_CYC = `GPCP_MS_CYC(`GPCP_DB16_MS),
   parameter int DB32_CYC = `GPCP_MS_CYC(`GPCP_DB32_MS)
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire gpcp_pkg::gpcp_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic pin_in,
   output gpcp_pkg::gpcp_pad_t pin_pad,
   output logic pin7_pullup_on,
   output logic irq
);
   import gpcp_pkg::*;

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [7:0] cfg_q;
   logic [7:0] pue_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic [7:0] rdata_q;
   gpcp_pad_t pad_q;
   logic pullup_q;
   logic irq_q;
   logic level_q;
   logic level_prev_q;
   gpcp_st_t st_q;
   logic [31:0] cnt_q;
   logic [31:0] db_lim;
   logic is_input;
   logic rise_ev;
   logic fall_ev;
   logic [1:0] ev_set;
   logic [1:0] w1c;

   // debounce limit decoder, shared by the filter and its check
   function automatic logic [31:0] db_limit(input logic [1:0] sel);
      case (sel)
         GPCP_DB_8MS: db_limit = 32'(DB8_CYC);
         GPCP_DB_16MS: db_limit = 32'(DB16_CYC);
         GPCP_DB_32MS: db_limit = 32'(DB32_CYC);
         default: db_limit = 32'h0;
      endcase
   endfunction : db_limit

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // pin 7 has no alternate polarity, the bit is direction only
   assign is_input = cfg_q[`GPCP_BIT_DIR];
   assign db_lim = db_limit(cfg_q[`GPCP_DBNC_HI:`GPCP_DBNC_LO]);

   // configuration register writes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= `GPCP_RST_CFG7;
      end else if (reg_req.wr && reg_req.addr == `GPCP_OFS_CFG7) begin
         if (is_input) begin
            cfg_q <= {reg_req.wdata[`GPCP_DBNC_HI:`GPCP_BIT_DO], level_q,
               reg_req.wdata[`GPCP_BIT_DIR:`GPCP_BIT_DRV]};
         end else begin
            cfg_q <= reg_req.wdata;
         end
      end else if (is_input) begin
         cfg_q[`GPCP_BIT_DI] <= level_q;
      end
   end

   // pull-up enables, one bit per pin
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pue_q <= `GPCP_RST_PUE;
      end else if (reg_req.wr && reg_req.addr == `GPCP_OFS_PUE) begin
         pue_q <= reg_req.wdata;
      end
   end

   // debounce filter on both edges; a change must hold for the full time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= 1'b0;
         st_q <= GPCP_ST_STABLE;
         cnt_q <= 32'h0;
      end else if (!is_input || db_lim == 32'h0) begin
         // filter bypassed in output mode or with no debounce
         level_q <= pin_in;
         st_q <= GPCP_ST_STABLE;
         cnt_q <= 32'h0;
      end else begin
         case (st_q)
            GPCP_ST_STABLE: begin
               cnt_q <= 32'h0;
               if (pin_in != level_q) begin
                  st_q <= GPCP_ST_CHANGE;
                  cnt_q <= 32'h1;
               end
            end
            GPCP_ST_CHANGE: begin
               if (pin_in == level_q) begin
                  st_q <= GPCP_ST_STABLE;
               end else if (cnt_q >= db_lim) begin
                  level_q <= pin_in;
                  st_q <= GPCP_ST_STABLE;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            default: begin
               st_q <= GPCP_ST_STABLE;
            end
         endcase
      end
   end

   // previous filtered level for edge detection
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         level_prev_q <= 1'b0;
      end else begin
         level_prev_q <= level_q;
      end
   end

   // edge select, ignored in output mode, on filtered level
   assign rise_ev = is_input && cfg_q[`GPCP_EDGE_HI] && level_q && !level_prev_q;
   assign fall_ev = is_input && cfg_q[`GPCP_EDGE_LO] && !level_q && level_prev_q;
   assign ev_set = {rise_ev, fall_ev};
   assign w1c = (reg_req.wr && reg_req.addr == `GPCP_OFS_IRQ_STAT) ? reg_req.wdata[1:0] : 2'h0;

   // sticky status, a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= `GPCP_RST_IRQ;
      end else begin
         stat_q <= (stat_q & ~w1c) | ev_set;
      end
   end

   // interrupt mask, 1 lets the status bit through
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= `GPCP_RST_IRQ;
      end else if (reg_req.wr && reg_req.addr == `GPCP_OFS_IRQ_MASK) begin
         mask_q <= reg_req.wdata[1:0];
      end
   end

   // registered interrupt level, one cycle behind status
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   // pad drive; drive type unused in input mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_q <= '0;
      end else if (is_input) begin
         pad_q <= '0;
      end else begin
         // low always driven, high only when push-pull
         pad_q.out <= cfg_q[`GPCP_BIT_DO];
         pad_q.oe <= !cfg_q[`GPCP_BIT_DO] || cfg_q[`GPCP_BIT_DRV];
      end
   end

   // pull-up for this pin follows its enable bit; pull choice is software's job
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_q <= 1'b0;
      end else begin
         pullup_q <= pue_q[`GPCP_PIN_NUM];
      end
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            `GPCP_OFS_CFG7: rdata_q <= cfg_q;
            `GPCP_OFS_PUE: rdata_q <= pue_q;
            `GPCP_OFS_IRQ_STAT: rdata_q <= {6'h00, stat_q};
            `GPCP_OFS_IRQ_MASK: rdata_q <= {6'h00, mask_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;
   assign pin_pad = pad_q;
   assign pin7_pullup_on = pullup_q;
   assign irq = irq_q;

   // debounce hold time; a mode switch is excluded
   a_db_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(is_input) && is_input && db_lim != 32'h0 && $changed(level_q)
      && $stable(cfg_q[`GPCP_DBNC_HI:`GPCP_DBNC_LO])) |-> $past(cnt_q) >= db_lim)
      else $error("debounce released too early");

   a_db_none: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && $past(is_input) && $past(db_lim) == 32'h0)
      |-> level_q == $past(pin_in))
      else $error("unfiltered level lags the pin");

   a_db_revert: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (is_input && db_lim != 32'h0 && st_q == GPCP_ST_CHANGE && pin_in == level_q)
      |=> (st_q == GPCP_ST_STABLE && $stable(level_q)))
      else $error("glitch reached the filtered level");

   // output mode bypass; the first cycle out of reset is skipped
   a_db_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && !$past(is_input)) |-> level_q == $past(pin_in))
      else $error("filter not bypassed in output mode");

   a_edge_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (is_input && cfg_q[`GPCP_EDGE_HI] && $rose(level_q))
      |=> stat_q[`GPCP_IRQ_RISE])
      else $error("rise event lost");

   a_edge_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (is_input && cfg_q[`GPCP_EDGE_LO] && $fell(level_q))
      |=> stat_q[`GPCP_IRQ_FALL])
      else $error("fall event lost");

   a_edge_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (is_input && cfg_q[`GPCP_EDGE_HI:`GPCP_EDGE_LO] == 2'h0) |-> ev_set == 2'h0)
      else $error("event with edge field masked");

   a_out_noedge: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !is_input |-> ev_set == 2'h0)
      else $error("event in output mode");

   a_out_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && !$past(is_input)) |-> pad_q.out == $past(cfg_q[`GPCP_BIT_DO]))
      else $error("wrong output level");

   a_in_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(is_input) && is_input) |-> cfg_q[`GPCP_BIT_DI] == $past(level_q))
      else $error("input level stale");

   a_in_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (is_input && reg_req.wr && reg_req.addr == `GPCP_OFS_CFG7)
      |=> cfg_q[`GPCP_BIT_DI] == $past(level_q))
      else $error("input level taken from software");

   a_out_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && !$past(cfg_q[`GPCP_BIT_DIR]) && !$past(cfg_q[`GPCP_BIT_DO]))
      |-> (pad_q.oe && !pad_q.out))
      else $error("output direction not driving low");

   a_out_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && !$past(is_input))
      |-> pad_q.oe == (!$past(cfg_q[`GPCP_BIT_DO]) || $past(cfg_q[`GPCP_BIT_DRV])))
      else $error("wrong output enable");

   a_in_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(is_input) |-> !pad_q.oe)
      else $error("pad driven in input mode");

   a_pue_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_req.wr && reg_req.addr == `GPCP_OFS_PUE)
      |=> pue_q == $past(reg_req.wdata))
      else $error("pull-up write lost");

   a_pue_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_req.rd && reg_req.addr == `GPCP_OFS_PUE) |=> rdata_q == $past(pue_q))
      else $error("pull-up read wrong");

   a_pullup_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> pullup_q == $past(pue_q[`GPCP_PIN_NUM]))
      else $error("pull-up taken from wrong bit");

   a_stat_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stat_q[`GPCP_IRQ_FALL] && !w1c[`GPCP_IRQ_FALL]) |=> stat_q[`GPCP_IRQ_FALL])
      else $error("status dropped");

   a_stat_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stat_q[`GPCP_IRQ_RISE] && !w1c[`GPCP_IRQ_RISE]) |=> stat_q[`GPCP_IRQ_RISE])
      else $error("rise status dropped");

   a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> irq_q == |($past(stat_q) & $past(mask_q)))
      else $error("interrupt level wrong");

endmodule : gpcp_pin7

//--- verification/gpcp_ext_pin.sv
/*
 * Behavioural model of the circuitry outside pin 7.
 * Assumes the bench supplies an optional external drive on the clock edge.
 */
`timescale 1ns/1ps

module gpcp_ext_pin (
   input wire logic ref_clk,
   input wire gpcp_pkg::gpcp_pad_t pin_pad,
   input wire logic pullup_on,
   input wire logic ext_en,
   input wire logic ext_val,
   output logic pin_level
);
   import gpcp_pkg::*;

   logic lvl_q = 1'b0;

   // pad level resolved on each rising edge; a floating pad toggles so it never looks stable
   // drive or release
   always @(posedge ref_clk) begin
      if (ext_en) begin
         lvl_q <= ext_val;
      end else if (pin_pad.oe) begin
         lvl_q <= pin_pad.out;
      end else if (pullup_on) begin
         lvl_q <= 1'b1;
      end else begin
         lvl_q <= ~lvl_q;
      end
   end

   assign pin_level = lvl_q;

endmodule : gpcp_ext_pin

//--- verification/gpcp_pin7_test.sv
/*
 * Self-checking bench for the pin 7 configuration block.
 * Assumes the package, the defines and the external pin model are compiled first.
 */
`timescale 1ns/1ps
`include "gpcp_defs.svh"

module gpcp_pin7_test;
   import gpcp_pkg::*;

   // short debounce limits keep the run brief
   localparam int DB_CYC [3] = '{4, 8, 16};

   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   gpcp_req_t reg_req = '0;
   logic [7:0] reg_rdata;
   gpcp_pad_t pin_pad;
   logic pin7_pullup_on;
   logic irq;
   logic pin_in;
   logic ext_en = 1'b0;
   logic ext_val = 1'b0;
   logic [7:0] rd_v;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;

   gpcp_pin7 #(.DB8_CYC(DB_CYC[0]), .DB16_CYC(DB_CYC[1]), .DB32_CYC(DB_CYC[2])) gpcp_pin7_i (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_pad(pin_pad), .pin7_pullup_on(pin7_pullup_on), .irq(irq));

   gpcp_ext_pin gpcp_ext_pin_i (
      .ref_clk(ref_clk), .pin_pad(pin_pad), .pullup_on(pin7_pullup_on),
      .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

   // free-running 10 MHz clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // cut a hang short well past the expected few hundred cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge ref_clk);
      reg_req.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge ref_clk);
      reg_req.rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
      chk(rd_v & m, e);
   endtask : rchk

   task automatic pin(input logic v, input int n);
      @(posedge ref_clk);
      ext_en <= 1'b1;
      ext_val <= v;
      repeat (n) @(posedge ref_clk);
   endtask : pin

   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk({6'h00, pin_pad}, 8'h01);
      rchk(`GPCP_OFS_CFG7, 8'hFF, 8'h00);
      rchk(`GPCP_OFS_PUE, 8'hFF, 8'h00);
      wr(`GPCP_OFS_PUE, 8'hA5);
      rchk(`GPCP_OFS_PUE, 8'hFF, 8'hA5);
      chk({7'h00, pin7_pullup_on}, 8'h01);
      wr(`GPCP_OFS_PUE, 8'h7F);
      rchk(`GPCP_OFS_PUE, 8'hFF, 8'h7F);
      chk({7'h00, pin7_pullup_on}, 8'h00);
      wr(`GPCP_OFS_PUE, 8'h00);
      rchk(8'h10, 8'hFF, 8'h00);
      // output mode: every level and drive pair, input-only fields set
      for (int i = 0; i < 4; i++) begin
         wr(`GPCP_OFS_CFG7, {4'hF, i[1], 2'b00, i[0]});
         repeat (2) @(posedge ref_clk);
         #1;
         chk({6'h00, pin_pad}, {6'h00, i[1], ~i[1] | i[0]});
      end
      pin(1'b1, 4);
      pin(1'b0, 4);
      rchk(`GPCP_OFS_IRQ_STAT, 8'hFF, 8'h00);
      wr(`GPCP_OFS_IRQ_MASK, 8'h03);
      // input mode, no debounce, every edge selection
      for (int c = 0; c < 4; c++) begin
         wr(`GPCP_OFS_CFG7, {2'b00, c[1:0], 4'h2});
         pin(1'b0, 4);
         wr(`GPCP_OFS_IRQ_STAT, 8'h03);
         pin(1'b1, 4);
         rchk(`GPCP_OFS_CFG7, 8'h04, 8'h04);
         pin(1'b0, 4);
         rchk(`GPCP_OFS_IRQ_STAT, 8'h03, {6'h00, c[1:0]});
         chk({7'h00, irq}, {7'h00, |c[1:0]});
      end
      wr(`GPCP_OFS_CFG7, 8'h07);
      rchk(`GPCP_OFS_CFG7, 8'hFF, 8'h03);
      chk({6'h00, pin_pad}, 8'h00);
      wr(`GPCP_OFS_IRQ_STAT, 8'h03);
      rchk(`GPCP_OFS_IRQ_STAT, 8'hFF, 8'h00);
      chk({7'h00, irq}, 8'h00);
      // masked event stays pending without an interrupt
      wr(`GPCP_OFS_IRQ_MASK, 8'h00);
      wr(`GPCP_OFS_CFG7, 8'h22);
      pin(1'b1, 4);
      rchk(`GPCP_OFS_IRQ_STAT, 8'hFF, 8'h02);
      chk({7'h00, irq}, 8'h00);
      // debounce: a short glitch is filtered, a long level gets through
      for (int d = 1; d < 4; d++) begin
         wr(`GPCP_OFS_CFG7, {d[1:0], 6'h02});
         pin(1'b0, 40);
         pin(1'b1, DB_CYC[d-1] / 2);
         pin(1'b0, 4);
         rchk(`GPCP_OFS_CFG7, 8'h04, 8'h00);
         pin(1'b1, DB_CYC[d-1] + 6);
         rchk(`GPCP_OFS_CFG7, 8'h04, 8'h04);
      end
      tally_and_finish();
   end

endmodule : gpcp_pin7_test
